// ---- rtl/csav_pkg.sv ----
package csav_pkg;

  // ****************************************************************
  // Host-visible port offsets and register numbering.
  // ****************************************************************
  localparam logic [7:0] CSAV_INDEX_SELECT_OFS = 8'hDC;
  localparam logic [7:0] CSAV_INDEXED_DATA_OFS = 8'hDD;
  localparam int CSAV_NUM_REGS = 18;
  localparam logic [4:0] CSAV_R_HTOTAL = 5'h00;
  localparam logic [4:0] CSAV_R_HDISP = 5'h01;
  localparam logic [4:0] CSAV_R_HSYNC_POS = 5'h02;
  localparam logic [4:0] CSAV_R_SYNC_WIDTH = 5'h03;
  localparam logic [4:0] CSAV_R_VTOTAL = 5'h04;
  localparam logic [4:0] CSAV_R_VDISP = 5'h06;
  localparam logic [4:0] CSAV_R_VSYNC_POS = 5'h07;
  localparam logic [4:0] CSAV_R_MAX_SCAN = 5'h09;
  localparam logic [4:0] CSAV_R_START_HI = 5'h0C;
  localparam logic [4:0] CSAV_R_START_LO = 5'h0D;
  localparam logic [4:0] CSAV_R_CURSOR_HI = 5'h0E;
  localparam logic [4:0] CSAV_R_CURSOR_LO = 5'h0F;

  // ****************************************************************
  // Reset values of the timing registers (80 x 25, nine scans).
  // ****************************************************************
  localparam logic [7:0] CSAV_HTOTAL_RST = 8'h61;
  localparam logic [7:0] CSAV_HDISP_RST = 8'h50;
  localparam logic [7:0] CSAV_HSYNC_POS_RST = 8'h52;
  localparam logic [7:0] CSAV_SYNC_WIDTH_RST = 8'h3A;
  localparam logic [7:0] CSAV_VTOTAL_RST = 8'h1A;
  localparam logic [7:0] CSAV_VDISP_RST = 8'h19;
  localparam logic [7:0] CSAV_VSYNC_POS_RST = 8'h19;
  localparam logic [7:0] CSAV_MAX_SCAN_RST = 8'h08;
  localparam logic [7:0] CSAV_ZERO_RST = 8'h00;

  // ****************************************************************
  // Timing: reference clock and nominal dot clock.
  // ****************************************************************
  localparam int CSAV_REF_CLK_KHZ = 125000;
  localparam int CSAV_DOT_CLK_KHZ = 14112;
  localparam int CSAV_DOT_DIV = CSAV_REF_CLK_KHZ / CSAV_DOT_CLK_KHZ;
  localparam logic [2:0] CSAV_LAST_DOT = 3'h7;
  localparam logic [2:0] CSAV_STROBE_DOT = 3'h5;
  localparam logic [2:0] CSAV_COLUMN_DOT = 3'h4;
  localparam int CSAV_FIFO_DEPTH = 8;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {
    CSAV_RAM_64K = 2'b00,
    CSAV_RAM_UPPER_32K = 2'b01,
    CSAV_RAM_LOWER_32K = 2'b10
  } csav_ram_size_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } csav_rgb_t;

  typedef struct packed {
    logic timing_ctrl_chip_select;
    logic bus_cycle_strobe;
    logic register_port_select_bit;
    logic host_write_n;
    logic bus_data_in_strobe;
    logic io_port_chip_select;
    logic [7:0] host_register_data;
  } csav_host_in_t;

endpackage

// ---- rtl/csav_video_path.sv ----
`timescale 1ns/1ps

// ******************************************************************
// Colour word FIFO.
// ******************************************************************
module csav_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;

  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
    end else if (in_valid && !full) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_ptr_reg <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // csav_fifo

// Behaviour
// - Index port write loads register number.
// - Data port reaches register the index selects.
// - Capture data on strobe falling edge; present while selected to read.
// - Direction low writes, otherwise reads.
// - Power-on clear resets all registers.
// - Reads enable inbound buffer via strobe and select.
// - Default format 25 rows, 80 chars, nine scans.
// - Line wraps to base; last scan advances base.
// - After last row, scan clears and address reloads start.
// - Vertical sync forwarded as host interrupt.
// - Scan count low four, character address above.
// - Row phase carries bits 9..4, 1, 2.
// - Column phase carries bits 15..10, 0, 3.
// - Top bit: bit 15, high or low.
// - Display owns RAM, read mode only with screen_wipe_n low.
// - Video strobe captures settled colour bytes.
// - Active-low load per character into shifters.
// - One dot per dot clock, eight per character.
// - Next byte held while current shifts.
// - Green-only keeps red and blue constant.
// - Display enable inactive during both retraces.
// - Enable and cursor delayed two characters.
module csav_video_path #(
  parameter int DOT_DIV = csav_pkg::CSAV_DOT_DIV,
  parameter int FIFO_DEPTH = csav_pkg::CSAV_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic power_on_clear,
  input wire csav_pkg::csav_host_in_t host_in,
  output logic [7:0] host_register_data_out,
  output logic host_register_data_oe_n,
  output logic read_buffer_select,
  output logic read_buffer_enable_n,
  output logic retrace_irq,
  input wire logic vram_cpu_owner_select,
  input wire logic screen_wipe_n,
  input wire logic [15:0] cpu_vram_address,
  input wire csav_pkg::csav_ram_size_t ram_size_mode,
  input wire logic green_only,
  input wire csav_pkg::csav_rgb_t vram_data,
  output logic vram_read_mode,
  output logic [15:0] vram_linear_address,
  output logic row_column_phase,
  output logic [7:0] dram_muxed_address,
  output logic video_latch_strobe,
  output logic shift_load_n,
  output logic red_dot,
  output logic green_dot,
  output logic blue_dot,
  output logic hsync,
  output logic vsync,
  output logic display_active_window,
  output logic display_active_delayed,
  output logic cursor_delayed
);
  import csav_pkg::*;

  // ****************************************************************
  // Input synchronisers and reset.
  // ****************************************************************
  localparam int SW = $bits(csav_host_in_t) + 2 + 16 + 2 + 1 + 24;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  csav_host_in_t hin;
  logic owner_s;
  logic wipe_n_s;
  logic [15:0] cpu_addr_s;
  csav_ram_size_t size_s;
  logic green_only_s;
  csav_rgb_t vram_s;
  logic poc_s1_reg;
  logic poc_s2_reg;
  logic rst;

  always_ff @(posedge ref_clk) begin
    sync1_reg <= {host_in, vram_cpu_owner_select, screen_wipe_n, cpu_vram_address,
                  ram_size_mode, green_only, vram_data};
    sync2_reg <= sync1_reg;
    poc_s1_reg <= power_on_clear;
    poc_s2_reg <= poc_s1_reg;
  end

  assign {hin, owner_s, wipe_n_s, cpu_addr_s, size_s, green_only_s, vram_s} = sync2_reg;
  assign rst = sys_rst | poc_s2_reg;

  // ****************************************************************
  // Host register access.
  // ****************************************************************
  logic [7:0] regs [0:CSAV_NUM_REGS-1];
  logic [4:0] index_reg;
  logic strobe_prev_reg;
  logic strobe_fall;
  logic host_wr;

  function automatic logic [7:0] reset_value(input int i);
    case (i)
      0: reset_value = CSAV_HTOTAL_RST;
      1: reset_value = CSAV_HDISP_RST;
      2: reset_value = CSAV_HSYNC_POS_RST;
      3: reset_value = CSAV_SYNC_WIDTH_RST;
      4: reset_value = CSAV_VTOTAL_RST;
      6: reset_value = CSAV_VDISP_RST;
      7: reset_value = CSAV_VSYNC_POS_RST;
      9: reset_value = CSAV_MAX_SCAN_RST;
      default: reset_value = CSAV_ZERO_RST;
    endcase
  endfunction

  function automatic logic [7:0] read_value(input logic sel, input logic [4:0] idx,
                                            input logic [7:0] val);
    if (!sel) begin
      read_value = {3'h0, idx};
    end else if (idx < 5'(CSAV_NUM_REGS)) begin
      read_value = val;
    end else begin
      read_value = 8'h00;
    end
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strobe_prev_reg <= 1'b0;
    end else begin
      strobe_prev_reg <= hin.bus_cycle_strobe;
    end
  end

  assign strobe_fall = strobe_prev_reg & ~hin.bus_cycle_strobe;
  assign host_wr = strobe_fall & hin.timing_ctrl_chip_select & ~hin.host_write_n;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      index_reg <= 5'h00;
    end else if (host_wr && !hin.register_port_select_bit) begin
      index_reg <= hin.host_register_data[4:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CSAV_NUM_REGS; gi++) begin : g_regs
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          regs[gi] <= reset_value(gi);
        end else if (host_wr && hin.register_port_select_bit && index_reg == 5'(gi)) begin
          regs[gi] <= hin.host_register_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_register_data_out <= 8'h00;
      host_register_data_oe_n <= 1'b1;
    end else begin
      host_register_data_out <= read_value(hin.register_port_select_bit, index_reg,
                                           regs[index_reg < 5'(CSAV_NUM_REGS) ?
                                                index_reg : 5'h00]);
      host_register_data_oe_n <= ~(hin.timing_ctrl_chip_select & hin.host_write_n);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      read_buffer_select <= 1'b0;
      read_buffer_enable_n <= 1'b1;
    end else begin
      read_buffer_select <= hin.timing_ctrl_chip_select | hin.io_port_chip_select;
      read_buffer_enable_n <= ~(hin.bus_data_in_strobe &
                                (hin.timing_ctrl_chip_select | hin.io_port_chip_select));
    end
  end

  // ****************************************************************
  // Dot and character timing.
  // ****************************************************************
  logic [7:0] div_reg;
  logic [2:0] dot_reg;
  logic dot_tick;
  logic char_tick;

  assign dot_tick = (div_reg == 8'(DOT_DIV - 1));
  assign char_tick = dot_tick && (dot_reg == CSAV_LAST_DOT);

  always_ff @(posedge ref_clk) begin
    if (rst || dot_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dot_reg <= 3'h0;
    end else if (dot_tick) begin
      dot_reg <= dot_reg + 3'h1;
    end
  end

  // ****************************************************************
  // Scan address generation.
  // ****************************************************************
  logic [7:0] hcount_reg;
  logic [3:0] scan_reg;
  logic [7:0] row_reg;
  logic [11:0] base_reg;
  logic [11:0] char_addr_reg;
  logic line_end;
  logic disp_now;
  logic cursor_now;
  logic [1:0] disp_dly_reg;
  logic [1:0] cursor_dly_reg;

  assign line_end = (hcount_reg == regs[CSAV_R_HTOTAL]);
  assign disp_now = (hcount_reg < regs[CSAV_R_HDISP]) && (row_reg < regs[CSAV_R_VDISP]);
  assign cursor_now = disp_now &&
                      (char_addr_reg == {regs[CSAV_R_CURSOR_HI][3:0], regs[CSAV_R_CURSOR_LO]});

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hcount_reg <= 8'h00;
      scan_reg <= 4'h0;
      row_reg <= 8'h00;
      base_reg <= 12'h000;
    end else if (char_tick) begin
      if (!line_end) begin
        hcount_reg <= hcount_reg + 8'h01;
      end else begin
        hcount_reg <= 8'h00;
        if (scan_reg != regs[CSAV_R_MAX_SCAN][3:0]) begin
          scan_reg <= scan_reg + 4'h1;
        end else if (row_reg != regs[CSAV_R_VTOTAL]) begin
          scan_reg <= 4'h0;
          row_reg <= row_reg + 8'h01;
          base_reg <= base_reg + {4'h0, regs[CSAV_R_HDISP]};
        end else begin
          scan_reg <= 4'h0;
          row_reg <= 8'h00;
          base_reg <= {regs[CSAV_R_START_HI][3:0], regs[CSAV_R_START_LO]};
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      char_addr_reg <= 12'h000;
    end else begin
      char_addr_reg <= base_reg + {4'h0, hcount_reg};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hsync <= 1'b0;
      vsync <= 1'b0;
      retrace_irq <= 1'b0;
      display_active_window <= 1'b0;
    end else begin
      hsync <= (hcount_reg >= regs[CSAV_R_HSYNC_POS]) &&
               (hcount_reg < regs[CSAV_R_HSYNC_POS] + {4'h0, regs[CSAV_R_SYNC_WIDTH][3:0]});
      vsync <= (row_reg == regs[CSAV_R_VSYNC_POS]) &&
               (scan_reg < regs[CSAV_R_SYNC_WIDTH][7:4]);
      retrace_irq <= (row_reg == regs[CSAV_R_VSYNC_POS]) &&
                     (scan_reg < regs[CSAV_R_SYNC_WIDTH][7:4]);
      display_active_window <= disp_now;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      disp_dly_reg <= 2'b00;
      cursor_dly_reg <= 2'b00;
    end else if (char_tick) begin
      disp_dly_reg <= {disp_dly_reg[0], disp_now};
      cursor_dly_reg <= {cursor_dly_reg[0], cursor_now};
    end
  end

  assign display_active_delayed = disp_dly_reg[1];
  assign cursor_delayed = cursor_dly_reg[1];

  // ****************************************************************
  // VRAM address path.
  // ****************************************************************
  logic top_bit;

  always_comb begin
    case (size_s)
      CSAV_RAM_64K: top_bit = vram_linear_address[15];
      CSAV_RAM_UPPER_32K: top_bit = 1'b1;
      CSAV_RAM_LOWER_32K: top_bit = 1'b0;
      default: top_bit = vram_linear_address[15];
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vram_linear_address <= 16'h0000;
      vram_read_mode <= 1'b1;
      row_column_phase <= 1'b1;
      dram_muxed_address <= 8'h00;
    end else begin
      vram_linear_address <= owner_s ? cpu_addr_s :
                             {base_reg + {4'h0, hcount_reg}, scan_reg};
      vram_read_mode <= ~owner_s & ~wipe_n_s;
      row_column_phase <= (dot_reg < CSAV_COLUMN_DOT);
      if (row_column_phase) begin
        dram_muxed_address <= {vram_linear_address[9:4], vram_linear_address[1],
                               vram_linear_address[2]};
      end else begin
        dram_muxed_address <= {top_bit, vram_linear_address[14:10], vram_linear_address[0],
                               vram_linear_address[3]};
      end
    end
  end

  // ****************************************************************
  // Colour capture, buffering and serialisation.
  // ****************************************************************
  csav_rgb_t hold_reg;
  logic push_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  csav_rgb_t fifo_out;
  logic load_now;
  logic [2:0][7:0] shift_reg;

  assign load_now = char_tick;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      video_latch_strobe <= 1'b0;
      push_reg <= 1'b0;
      hold_reg <= '0;
    end else begin
      video_latch_strobe <= dot_tick && (dot_reg == CSAV_STROBE_DOT) && fifo_in_ready;
      push_reg <= video_latch_strobe;
      if (video_latch_strobe) begin
        hold_reg.green <= vram_s.green;
        hold_reg.red <= green_only_s ? 8'h00 : vram_s.red;
        hold_reg.blue <= green_only_s ? 8'h00 : vram_s.blue;
      end
    end
  end

  csav_fifo #(
    .WIDTH($bits(csav_rgb_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(push_reg),
    .in_ready(fifo_in_ready),
    .in_data(hold_reg),
    .out_valid(fifo_out_valid),
    .out_ready(load_now),
    .out_data(fifo_out)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_load_n <= 1'b1;
    end else begin
      shift_load_n <= ~load_now;
    end
  end

  generate
    for (gi = 0; gi < 3; gi++) begin : g_shift
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          shift_reg[gi] <= 8'h00;
        end else if (load_now) begin
          shift_reg[gi] <= fifo_out_valid ? fifo_out[gi*8 +: 8] : 8'h00;
        end else if (dot_tick) begin
          shift_reg[gi] <= {shift_reg[gi][6:0], 1'b0};
        end
      end
    end
  endgenerate

  assign blue_dot = shift_reg[0][7];
  assign green_dot = shift_reg[1][7];
  assign red_dot = shift_reg[2][7];
endmodule // csav_video_path

// ---- verif/csav_video_path_assertions.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the video path.
// ****************************************************************
module csav_video_path_chk #(
  parameter int DOT_DIV = 8,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic power_on_clear,
  input wire logic vram_cpu_owner_select,
  input wire logic screen_wipe_n,
  input wire csav_pkg::csav_ram_size_t ram_size_mode,
  input wire logic green_only,
  input wire logic vram_read_mode,
  input wire logic [15:0] vram_linear_address,
  input wire logic row_column_phase,
  input wire logic [7:0] dram_muxed_address,
  input wire logic video_latch_strobe,
  input wire logic shift_load_n,
  input wire logic red_dot,
  input wire logic green_dot,
  input wire logic blue_dot,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic retrace_irq,
  input wire logic display_active_window,
  input wire logic display_active_delayed,
  input wire logic cursor_delayed
);
  import csav_pkg::*;
  logic [3:0] own_h, wipe_h;
  logic [2:0] mode_age;
  logic [9:0] gro_age;
  csav_ram_size_t mode_q;
  logic top_e;
  assign top_e = (ram_size_mode == CSAV_RAM_UPPER_32K) ? 1'b1 :
    (ram_size_mode == CSAV_RAM_LOWER_32K) ? 1'b0 : vram_linear_address[15];
  always_ff @(posedge ref_clk) begin
    own_h <= {own_h[2:0], vram_cpu_owner_select};
    wipe_h <= {wipe_h[2:0], screen_wipe_n};
  end
  always_ff @(posedge ref_clk) begin
    mode_q <= ram_size_mode;
    if (sys_rst || ram_size_mode != mode_q) begin
      mode_age <= 3'h0;
    end else if (mode_age != 3'h7) begin
      mode_age <= mode_age + 3'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!green_only) begin
      gro_age <= 10'h000;
    end else if (gro_age != 10'h3FF) begin
      gro_age <= gro_age + 10'h001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst || power_on_clear);
  load_pulse_a: assert property ($fell(shift_load_n) |=> shift_load_n)
    else $error("shift load low longer than one cycle");
  load_rate_a: assert property ($fell(shift_load_n) |-> ##64 $fell(shift_load_n))
    else $error("shift load not once per character");
  strobe_pulse_a: assert property ($rose(video_latch_strobe) |=> !video_latch_strobe)
    else $error("video strobe longer than one cycle");
  row_map_a: assert property (row_column_phase && $stable(row_column_phase)
    && $stable(vram_linear_address) |-> dram_muxed_address == {vram_linear_address[9:4],
    vram_linear_address[1], vram_linear_address[2]}) else $error("row phase address wrong");
  col_map_a: assert property (!row_column_phase && $stable(row_column_phase)
    && $stable(vram_linear_address) && mode_age > 3'h4 |-> dram_muxed_address == {top_e,
    vram_linear_address[14:10], vram_linear_address[0], vram_linear_address[3]})
    else $error("column phase address wrong");
  cpu_owner_a: assert property (own_h == 4'hF |-> !vram_read_mode)
    else $error("read mode while cpu owns ram");
  read_mode_a: assert property (own_h == 4'h0 && wipe_h == 4'h0 |-> vram_read_mode)
    else $error("display fetch not in read mode");
  retrace_blank_a: assert property (hsync || vsync |-> !display_active_window)
    else $error("display enabled during retrace");
  retrace_irq_a: assert property (retrace_irq == vsync)
    else $error("retrace interrupt differs from vertical sync");
  enable_delay_a: assert property ($rose(display_active_window) |->
    ##120 !display_active_delayed ##[1:16] display_active_delayed)
    else $error("delayed enable not two characters late");
  cursor_align_a: assert property (cursor_delayed |-> display_active_delayed)
    else $error("delayed cursor outside delayed display window");
  green_only_a: assert property (gro_age > 10'h2BC |-> !red_dot && !blue_dot)
    else $error("red or blue dot in green only mode");
  dot_rate_a: assert property ($changed(green_dot) |=> $stable(green_dot) [*7])
    else $error("dot shorter than one dot clock");
endmodule // csav_video_path_chk

bind csav_video_path csav_video_path_chk #(.DOT_DIV(DOT_DIV), .FIFO_DEPTH(FIFO_DEPTH))
  u_csav_video_path_chk (.*);

// ---- verif/csav_host_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Host processor on the backplane bus.
// ****************************************************************
module csav_host_model (
  input wire logic ref_clk,
  output csav_pkg::csav_host_in_t host_in,
  input wire logic [7:0] host_register_data_out,
  input wire logic host_register_data_oe_n
);
  import csav_pkg::*;
  logic cs = 1'b0, stb = 1'b1, sel = 1'b0, wn = 1'b1, dbin = 1'b0, drv = 1'b0;
  logic [7:0] wdat = 8'h00, last = 8'h00, bus;
  // A released bus shows a changing pattern.
  assign bus = !host_register_data_oe_n ? host_register_data_out : (drv ? wdat : ~last);
  assign host_in = '{cs, stb, sel, wn, dbin, 1'b0, bus};
  always_ff @(posedge ref_clk) begin
    last <= bus;
  end
  task automatic start(input logic s, input logic w, input logic [7:0] d);
    cs = 1'b1;
    sel = s;
    wn = !w;
    dbin = !w;
    drv = w;
    wdat = d;
    repeat (4) @(posedge ref_clk);
    #1 stb = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic finish(output logic [7:0] rd);
    rd = bus;
    cs = 1'b0;
    stb = 1'b1;
    wn = 1'b1;
    dbin = 1'b0;
    drv = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
endmodule // csav_host_model

// ---- verif/csav_video_path_tb.sv ----
`timescale 1ns/1ps
module csav_video_path_tb;
  import csav_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, power_on_clear = 1'b0;
  csav_host_in_t host_in;
  logic [7:0] host_register_data_out, dram_muxed_address, d;
  logic host_register_data_oe_n, read_buffer_select, read_buffer_enable_n, retrace_irq;
  logic vram_cpu_owner_select, screen_wipe_n, green_only, vram_read_mode, row_column_phase;
  logic video_latch_strobe, shift_load_n, red_dot, green_dot, blue_dot, hsync, vsync;
  logic display_active_window, display_active_delayed, cursor_delayed;
  logic [15:0] cpu_vram_address, vram_linear_address;
  csav_ram_size_t ram_size_mode;
  csav_rgb_t vram_data;
  int bad_count = 0, total_checks = 0;
  logic [7:0] rst_tab [18] = '{8'h61, 8'h50, 8'h52, 8'h3A, 8'h1A, 8'h00, 8'h19, 8'h19,
    8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [4:0] t_idx [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h09,
    5'h0C, 5'h0D};
  logic [7:0] t_val [10] = '{8'h0F, 8'h08, 8'h0A, 8'h12, 8'h03, 8'h02, 8'h03, 8'h02,
    8'h00, 8'h00};
  logic [15:0] m_adr [3] = '{16'h3EEF, 16'h3EEF, 16'hBEEF};
  logic m_top [3] = '{1'b0, 1'b1, 1'b0};
  always #4 ref_clk = ~ref_clk;
  csav_video_path u_csav_video_path (.*);
  csav_host_model u_csav_host_model (.ref_clk(ref_clk), .host_in(host_in),
    .host_register_data_out(host_register_data_out),
    .host_register_data_oe_n(host_register_data_oe_n));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [4:0] idx, input logic [7:0] val);
    u_csav_host_model.start(1'b0, 1'b1, {3'h0, idx});
    u_csav_host_model.finish(d);
    u_csav_host_model.start(1'b1, 1'b1, val);
    u_csav_host_model.finish(d);
  endtask
  task automatic rd_reg(input logic [4:0] idx, input logic [7:0] exp, input string nm);
    u_csav_host_model.start(1'b0, 1'b1, {3'h0, idx});
    u_csav_host_model.finish(d);
    u_csav_host_model.start(1'b1, 1'b0, 8'h00);
    chk("read buffer select", 16'h1, {15'h0, read_buffer_select});
    chk("read buffer enable", 16'h0, {15'h0, read_buffer_enable_n});
    u_csav_host_model.finish(d);
    chk(nm, {8'h00, exp}, {8'h00, d});
  endtask
  task automatic wait_vla(input logic [15:0] exp, input logic [15:0] msk, input int lim);
    int n = 0;
    while ((vram_linear_address & msk) !== (exp & msk) && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("scan address", exp, vram_linear_address);
  endtask
  task automatic dots(input int er, input int eg, input int eb);
    int r = 0, g = 0, b = 0;
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk);
      #1;
      r += (red_dot === 1'b1);
      g += (green_dot === 1'b1);
      b += (blue_dot === 1'b1);
    end
    chk("red dots", er[15:0], r[15:0]);
    chk("green dots", eg[15:0], g[15:0]);
    chk("blue dots", eb[15:0], b[15:0]);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #(100000 * 8);
    bad_count++;
    results();
  end
  initial begin
    vram_cpu_owner_select = 1'b0;
    screen_wipe_n = 1'b0;
    cpu_vram_address = 16'h0000;
    ram_size_mode = CSAV_RAM_64K;
    green_only = 1'b0;
    vram_data = 24'h803CFF;
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 18; i++) rd_reg(i[4:0], rst_tab[i], "reset value");
    u_csav_host_model.start(1'b0, 1'b0, 8'h00);
    u_csav_host_model.finish(d);
    chk("index readback", 16'h0011, {8'h00, d});
    wr_reg(5'h12, 8'h5A);
    rd_reg(5'h12, 8'h00, "unmapped register");
    $display("test registers done");
    for (int i = 0; i < 10; i++) wr_reg(t_idx[i], t_val[i]);
    for (int i = 0; i < 10; i++) rd_reg(t_idx[i], t_val[i], "timing register");
    wait_vla(16'h0000, 16'hFFFF, 40000);
    @(posedge ref_clk);
    #1;
    wait_vla(16'h0010, 16'hFFF0, 80);
    wait_vla(16'h0001, 16'h000F, 2000);
    for (int n = 0; n < 15000 && retrace_irq !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("retrace interrupt", 16'h1, {15'h0, retrace_irq});
    wr_reg(CSAV_R_START_LO, 8'h40);
    wait_vla(16'h0400, 16'hFFFF, 15000);
    $display("test scan addressing done");
    vram_cpu_owner_select = 1'b1;
    for (int m = 0; m < 3; m++) begin
      ram_size_mode = csav_ram_size_t'(m);
      cpu_vram_address = m_adr[m];
      repeat (300) @(posedge ref_clk);
      #1;
      chk("cpu address", m_adr[m], vram_linear_address);
      chk("read mode", 16'h0, {15'h0, vram_read_mode});
      while (row_column_phase !== 1'b0) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("column address", {8'h00, m_top[m], m_adr[m][14:10], m_adr[m][0], m_adr[m][3]},
        {8'h00, dram_muxed_address});
      while (row_column_phase !== 1'b1) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("row address", {8'h00, m_adr[m][9:4], m_adr[m][1], m_adr[m][2]},
        {8'h00, dram_muxed_address});
    end
    vram_cpu_owner_select = 1'b0;
    ram_size_mode = CSAV_RAM_64K;
    $display("test ram mapping done");
    repeat (700) @(posedge ref_clk);
    #1;
    dots(8, 32, 64);
    green_only = 1'b1;
    repeat (800) @(posedge ref_clk);
    #1;
    dots(0, 32, 0);
    green_only = 1'b0;
    $display("test dot stream done");
    power_on_clear = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 power_on_clear = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    rd_reg(CSAV_R_HTOTAL, 8'h61, "cleared register");
    rd_reg(CSAV_R_MAX_SCAN, 8'h08, "cleared register");
    $display("test power on clear done");
    results();
  end
endmodule // csav_video_path_tb
